/* lsft_sink_fade.sv */
// sink 1 fade engine: fade register, level register, ramp and hold-off
// assumes register port and blink-timer inputs are synchronous to mclk
//
// How it works
// - fade-out duration comes from bits 7:4; zero drops the current at once.
// - codes 1-10 give 0.05 s steps, codes 11-15 give 0.75-1.75 s.
// - fade-out time spans full scale to zero, whatever range is selected.
// - fade-in duration comes from bits 3:0; zero raises the current at once.
// - fade-in uses the same table, spanning zero to range full scale.
// - off-time setting 'off' keeps the LED dark once its off phase starts.
// - level register holds a 7-bit code; bit 7 is reserved and reads zero.
// - code 0x00 is zero current, 0x7f full scale, scaled by the range.
// - disabled off time keeps an enabled sink continuously on.
`default_nettype none
module lsft_sink_fade
  import lsft_pkg::*;
#(
  parameter logic [LSFT_UNIT_W-1:0] UNIT_CYC = LSFT_UNIT_W'(LSFT_UNIT_STEP_CYC),
  parameter int RANGE_W = 6
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // blink timer and range select
  input wire logic sink_en,
  input wire logic blink_on_phase,
  input wire logic [6:0] sink_off_time,
  input wire logic [RANGE_W-1:0] full_scale_sel,
  // to the current dac
  output logic [6:0] led1_sink_level_code,
  output logic [RANGE_W-1:0] dac_range,
  output logic sink_held_off,
  output logic fade_active
);
  // ==========================================================
  // fade code to 50 ms units: fine codes linear, coarse in 250 ms
  function automatic logic [LSFT_MULT_W-1:0] fade_units(input logic [3:0] code);
    logic [LSFT_MULT_W-1:0] c;
    c = LSFT_MULT_W'(code);
    if (code <= LSFT_FADE_LINEAR_TOP) begin
      fade_units = c;
    end else begin
      fade_units = LSFT_MULT_W'((c - LSFT_MULT_W'(LSFT_FADE_LINEAR_TOP)) * LSFT_FADE_COARSE_MULT
                   + LSFT_MULT_W'(LSFT_FADE_LINEAR_TOP));
    end
  endfunction

  // ==========================================================
  // state
  logic [7:0] fade_times_ff;
  logic [6:0] sink1_level_ff;
  logic [6:0] level_ff;
  logic [7:0] rdata_ff;
  logic [RANGE_W-1:0] range_ff;
  logic held_ff;
  logic phase_prev_ff;
  logic busy_ff;

  lsft_step_if st();

  lsft_step_timer #(
    .UNIT_CYC(UNIT_CYC)
  ) u_timer (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .st(st)
  );

  // ==========================================================
  // register decode
  wire wr_fade = reg_wr && (reg_addr == LSFT_ADDR_FADE_TIMES);
  wire wr_level = reg_wr && (reg_addr == LSFT_ADDR_SINK1_LEVEL);
  wire [3:0] sink_fade_out_code = fade_times_ff[LSFT_FO_MSB:LSFT_FO_LSB];
  wire [3:0] sink_fade_in_code = fade_times_ff[LSFT_FI_MSB:LSFT_FI_LSB];
  // reserved bit is never stored, so it always reads back zero
  wire [7:0] nxt_rdata = (reg_addr == LSFT_ADDR_FADE_TIMES) ? fade_times_ff :
                         (reg_addr == LSFT_ADDR_SINK1_LEVEL) ? {1'b0, sink1_level_ff} :
                         LSFT_READ_UNMAPPED;
  wire [6:0] nxt_sink1_level = wr_level ? reg_wdata[6:0] : sink1_level_ff;
  wire [7:0] nxt_fade_times = wr_fade ? reg_wdata : fade_times_ff;

  // ==========================================================
  // on/off decision from the blink timer
  wire off_disabled = (sink_off_time == LSFT_OFF_DISABLED);
  wire off_start = phase_prev_ff && !blink_on_phase;
  // hold is sticky until the sink is disabled, so a one-shot blink stays dark
  wire nxt_held = sink_en && (held_ff || (off_start && sink_off_time == LSFT_OFF_HOLD));
  wire lit = sink_en && !held_ff && (off_disabled || blink_on_phase);
  // target is a code, so full scale follows whatever range is selected
  wire [6:0] target = lit ? sink1_level_ff : LSFT_LEVEL_ZERO;

  // ==========================================================
  // ramp direction and speed
  wire rising = target > level_ff;
  wire moving = target != level_ff;
  wire [3:0] sel_code = rising ? sink_fade_in_code : sink_fade_out_code;
  wire no_fade = (sel_code == LSFT_FADE_OFF);
  // one code step per period: a short fade ends early at the same rate
  assign st.units = fade_units(sel_code);
  assign st.run = moving && !no_fade && busy_ff;
  wire [6:0] step_level = rising ? level_ff + 7'h01 : level_ff - 7'h01;
  wire [6:0] nxt_level = !moving ? level_ff :
                         no_fade ? target :
                         st.step ? step_level : level_ff;
  // busy gates the timer one cycle so a fresh fade restarts its period
  wire nxt_busy = moving && !no_fade;

  // ==========================================================
  // register file and port capture
  always_ff @(posedge mclk) begin
    if (srst) begin
      fade_times_ff <= LSFT_FADE_TIMES_RST;
      sink1_level_ff <= LSFT_SINK1_LEVEL_RST;
      rdata_ff <= LSFT_READ_UNMAPPED;
      range_ff <= '0;
    end else if (ce) begin
      fade_times_ff <= nxt_fade_times;
      sink1_level_ff <= nxt_sink1_level;
      rdata_ff <= nxt_rdata;
      range_ff <= full_scale_sel;
    end
  end

  // ==========================================================
  // ramp and hold state
  always_ff @(posedge mclk) begin
    if (srst) begin
      level_ff <= LSFT_LEVEL_ZERO;
      held_ff <= 1'b0;
      phase_prev_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      level_ff <= nxt_level;
      held_ff <= nxt_held;
      phase_prev_ff <= blink_on_phase;
      busy_ff <= nxt_busy;
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  assign reg_rdata = rdata_ff;
  assign led1_sink_level_code = level_ff;
  assign dac_range = range_ff;
  assign sink_held_off = held_ff;
  assign fade_active = busy_ff;
endmodule
`default_nettype wire

/* lsft_pkg.sv */
// constants shared by the sink 1 fade engine and its step timer
// assumes a 10 MHz mclk and an 8-bit register port inside the device
`default_nettype none
package lsft_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] LSFT_ADDR_FADE_TIMES = 8'h22;
  localparam logic [7:0] LSFT_ADDR_SINK1_LEVEL = 8'h23;
  localparam logic [7:0] LSFT_FADE_TIMES_RST = 8'h00;
  localparam logic [6:0] LSFT_SINK1_LEVEL_RST = 7'h00;
  localparam logic [7:0] LSFT_READ_UNMAPPED = 8'h00;
  // ==========================================================
  // field positions in the fade register
  localparam int LSFT_FO_MSB = 7;
  localparam int LSFT_FO_LSB = 4;
  localparam int LSFT_FI_MSB = 3;
  localparam int LSFT_FI_LSB = 0;
  localparam logic [3:0] LSFT_FADE_OFF = 4'h0;
  localparam logic [3:0] LSFT_FADE_LINEAR_TOP = 4'ha;
  localparam logic [5:0] LSFT_FADE_COARSE_MULT = 6'h05;
  // ==========================================================
  // off-time codes of the blink timer
  localparam logic [6:0] LSFT_OFF_DISABLED = 7'h00;
  localparam logic [6:0] LSFT_OFF_HOLD = 7'h7f;
  // ==========================================================
  // level codes and timing
  localparam logic [6:0] LSFT_LEVEL_ZERO = 7'h00;
  localparam logic [6:0] LSFT_LEVEL_FULL = 7'h7f;
  localparam int LSFT_CLK_KHZ = 10000;
  localparam int LSFT_FADE_UNIT_MS = 50;
  localparam int LSFT_FULL_STEPS = 127;
  // cycles per code step for one 50 ms unit of fade time, rounded down
  localparam int LSFT_UNIT_STEP_CYC = LSFT_FADE_UNIT_MS * LSFT_CLK_KHZ / LSFT_FULL_STEPS;
  localparam int LSFT_UNIT_W = 12;
  localparam int LSFT_MULT_W = 6;
  localparam int LSFT_CNT_W = LSFT_UNIT_W + LSFT_MULT_W;
  localparam logic [LSFT_CNT_W-1:0] LSFT_CNT_ZERO = '0;
endpackage
`default_nettype wire

/* lsft_step_if.sv */
// carrier between the fade engine and its step timer
// assumes both ends share mclk
`default_nettype none
interface lsft_step_if;
  import lsft_pkg::*;
  logic run;
  logic [LSFT_MULT_W-1:0] units;
  logic step;
  modport engine (output run, output units, input step);
  modport timer (input run, input units, output step);
endinterface
`default_nettype wire

/* lsft_step_timer.sv */
// step timer: one pulse per level step while a fade runs
// assumes units is held steady while run is high
`default_nettype none
module lsft_step_timer
  import lsft_pkg::*;
#(
  parameter logic [LSFT_UNIT_W-1:0] UNIT_CYC = LSFT_UNIT_W'(LSFT_UNIT_STEP_CYC)
) (
  // clock and control
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // engine side
  lsft_step_if.timer st
);
  logic [LSFT_CNT_W-1:0] cnt_ff;
  logic step_ff;
  wire [LSFT_CNT_W-1:0] limit = LSFT_CNT_W'(st.units) * LSFT_CNT_W'(UNIT_CYC);
  wire at_end = (cnt_ff + LSFT_CNT_W'(1)) >= limit;
  wire [LSFT_CNT_W-1:0] nxt_cnt = (!st.run || at_end) ? LSFT_CNT_ZERO : cnt_ff + LSFT_CNT_W'(1);
  wire nxt_step = st.run && at_end;

  assign st.step = step_ff;

  // ==========================================================
  // period counter; stopping resets it so each fade starts clean
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_ff <= LSFT_CNT_ZERO;
      step_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      step_ff <= nxt_step;
    end
  end
endmodule
`default_nettype wire

/* lsft_chk_properties.sv */
// port checker for the sink 1 fade engine
// assumes a bind from the bench and the single mclk domain
`default_nettype none
module lsft_chk
  import lsft_pkg::*;
#(parameter int RANGE_W = 6) (
  // watched ports, grouped by width
  input wire logic mclk, srst, ce, reg_wr, sink_en, blink_on_phase,
  input wire logic sink_held_off, fade_active,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [6:0] sink_off_time, led1_sink_level_code,
  input wire logic [RANGE_W-1:0] full_scale_sel, dac_range
);
  // ==========================================================
  // properties; reset masks all but the reset check
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_reset_clear: assert property (disable iff (1'b0) srst && ce |=>
    led1_sink_level_code == 7'h00 && !fade_active && !sink_held_off && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  a_range_follow: assert property (ce |=> dac_range == $past(full_scale_sel))
    else $error("range select not passed on");
  a_bit7_zero: assert property (ce && reg_addr == LSFT_ADDR_SINK1_LEVEL |=> !reg_rdata[7])
    else $error("reserved level bit reads set");
  a_unmapped_zero: assert property (ce && reg_addr != LSFT_ADDR_FADE_TIMES &&
    reg_addr != LSFT_ADDR_SINK1_LEVEL |=> reg_rdata == LSFT_READ_UNMAPPED)
    else $error("unmapped read not zero");
  a_fade_readback: assert property ((ce && reg_wr && reg_addr == LSFT_ADDR_FADE_TIMES) ##1
    (ce && !reg_wr && reg_addr == LSFT_ADDR_FADE_TIMES) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("fade register readback wrong");
  a_level_readback: assert property ((ce && reg_wr && reg_addr == LSFT_ADDR_SINK1_LEVEL) ##1
    (ce && !reg_wr && reg_addr == LSFT_ADDR_SINK1_LEVEL) |=>
    reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
    else $error("level register readback wrong");
  a_hold_set: assert property (ce && sink_en && sink_off_time == LSFT_OFF_HOLD &&
    $fell(blink_on_phase) |=> sink_held_off)
    else $error("hold-off not latched");
  a_hold_clear: assert property (ce && !sink_en |=> !sink_held_off)
    else $error("hold-off kept with sink disabled");
  a_step_size: assert property (ce && fade_active |=>
    7'(led1_sink_level_code - $past(led1_sink_level_code)) inside {7'h00, 7'h01, 7'h7f})
    else $error("ramp moved more than one code");
endmodule
`default_nettype wire

/* tb.sv */
// bench for the sink 1 fade engine: register port, ramps, hold-off
// assumes package, engine, step timer and checker compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lsft_pkg::*;
  // ==========================================================
  // stimulus and observed signals; small step unit keeps runs short
  localparam int UC = 8;
  logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, reg_wr = 1'b0, sink_en = 1'b0;
  logic blink_on_phase = 1'b0, sink_held_off, fade_active;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [6:0] sink_off_time = 7'h00, led1_sink_level_code;
  logic [5:0] full_scale_sel = 6'h00, dac_range;
  logic [31:0] seed = 32'h67b7;
  int n_errors = 0, checks = 0;
  always #50 mclk = ~mclk;
  lsft_sink_fade #(.UNIT_CYC(12'(UC))) lsft_sink_fade_i (.mclk, .srst, .ce, .reg_wr,
    .reg_addr, .reg_wdata, .reg_rdata, .sink_en, .blink_on_phase, .sink_off_time,
    .full_scale_sel, .led1_sink_level_code, .dac_range, .sink_held_off, .fade_active);
  // ==========================================================
  // helpers: random source, duration table, checks, bus cycles
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int units(int c);
    return (c <= 10) ? c : (c - 10) * 5 + 10;
  endfunction
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(logic [7:0] a);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
  endtask
  // elapsed cycles over one step period must equal the code distance
  task automatic ramp(logic en, int steps, int u, logic [6:0] goal);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    sink_en <= en;
    while (led1_sink_level_code !== goal && n < 2000) begin
      @(posedge mclk);
      n++;
      if (fade_active === 1'b1) seen = 1'b1;
    end
    if (n == 2000) begin
      n_errors++;
      print_verdict();
    end
    chk(8'(n / (u * UC)), 8'(steps));
    chk({7'h00, seen}, 8'(steps != 0));
    // busy drops one edge after the goal is reached
    repeat (2) @(posedge mclk);
    chk({7'h00, fade_active}, 8'h00);
    chk({2'b00, dac_range}, {2'b00, full_scale_sel});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    rd(LSFT_ADDR_FADE_TIMES);
    chk(reg_rdata, LSFT_FADE_TIMES_RST);
    for (int i = 0; i < 4; i++) begin
      d = 8'(rnd());
      full_scale_sel <= 6'(rnd());
      wr(LSFT_ADDR_FADE_TIMES, d);
      rd(LSFT_ADDR_FADE_TIMES);
      chk(reg_rdata, d);
      wr(LSFT_ADDR_SINK1_LEVEL, d);
      rd(LSFT_ADDR_SINK1_LEVEL);
      chk(reg_rdata, {1'b0, d[6:0]});
      rd(d | 8'h80);
      chk(reg_rdata, LSFT_READ_UNMAPPED);
    end
    $display("register test done");
    for (int c = 1; c < 16; c++) begin
      d = 8'(rnd() % 3 + 1);
      wr(LSFT_ADDR_FADE_TIMES, {c[3:0], c[3:0]});
      wr(LSFT_ADDR_SINK1_LEVEL, d);
      ramp(1'b1, d, units(c), d[6:0]);
      ramp(1'b0, d, units(c), 7'h00);
    end
    $display("fade test done");
    wr(LSFT_ADDR_FADE_TIMES, 8'h00);
    wr(LSFT_ADDR_SINK1_LEVEL, 8'h40);
    sink_off_time <= LSFT_OFF_HOLD;
    blink_on_phase <= 1'b1;
    ramp(1'b1, 0, 1, 7'h40);
    blink_on_phase <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({7'h00, sink_held_off}, 8'h01);
    blink_on_phase <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({1'b0, led1_sink_level_code}, 8'h00);
    sink_en <= 1'b0;
    sink_off_time <= LSFT_OFF_DISABLED;
    blink_on_phase <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({7'h00, sink_held_off}, 8'h00);
    ramp(1'b1, 0, 1, 7'h40);
    $display("hold test done");
    print_verdict();
  end
endmodule
bind lsft_sink_fade lsft_chk #(.RANGE_W(RANGE_W)) lsft_chk_i (.mclk, .srst, .ce, .reg_wr,
  .reg_addr, .reg_wdata, .reg_rdata, .sink_en, .blink_on_phase, .sink_off_time,
  .full_scale_sel, .led1_sink_level_code, .dac_range, .sink_held_off, .fade_active);
`default_nettype wire
